// File: hw/handler_io_params.svh
// Purpose: Constants for the handler/scan result connector logic.
// Assumes: Register port with byte addresses, one 32-bit word each.
// Notes: Pin macros give connector pin numbers, 1 to 25.
`ifndef HANDLER_IO_PARAMS_SVH
`define HANDLER_IO_PARAMS_SVH

// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_USER 8'h04
`define REG_SCAN 8'h08
`define REG_STAT 8'h0C
`define CTRL_EXT_BIT 2
`define CTRL_RELAY_BIT 3
`define USER_B_LSB 8
`define SCAN_MAX 7'h64
`define PULSE_CYC 4'h2
`define PULSE_W 4
`define NUM_PINS 25

// ----------------------------------------
// Compare and binning pin map
// ----------------------------------------
`define PIN_FAIL 5'h04
`define PIN_HIGH 5'h05
`define PIN_PASS 5'h06
`define PIN_CONV_DONE 5'h07
`define PIN_SLOT1 5'h09
`define PIN_SLOT2 5'h0A
`define PIN_SLOT3 5'h0B
`define PIN_SLOT4 5'h0C
`define PIN_SLOT5 5'h0D
`define PIN_USER_B 5'h0F
`define PIN_USER_A 5'h10
`define PIN_READY 5'h14
`define PIN_SLOT6 5'h15
`define PIN_LOW 5'h16
`define PIN_SLOT7 5'h17
`define PIN_SLOT8 5'h18
`define PIN_SLOT_OUT 5'h19

// ----------------------------------------
// Scan pin map
// ----------------------------------------
`define PIN_S_HIGH 5'h04
`define PIN_S_CLOCK 5'h05
`define PIN_S_LOW 5'h06
`define PIN_S_PASS 5'h07
`define PIN_S_RELAY 5'h14
`define PIN_S_BATCH 5'h16

`endif

// File: hw/handler_io_pkg.sv
// Purpose: Types for the handler/scan result connector logic.
// Assumes: handler_io_params.svh is on the include path.
// Notes: State of each clock domain is one packed struct.
`include "handler_io_params.svh"
`default_nettype none

package handler_io_pkg;

   typedef enum logic [1:0] {
      MODE_CMP = 2'h0,
      MODE_BIN = 2'h1,
      MODE_SCAN = 2'h2,
      MODE_OFF = 2'h3
   } mode_t;

   // Gray order along idle, measure, send, last
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_MEAS = 2'h1,
      ST_SEND = 2'h3,
      ST_LAST = 2'h2
   } state_t;

   typedef struct packed {
      mode_t mode;
      logic pass;
      logic fail;
      logic high;
      logic low;
      logic [7:0] grade_slots;
      logic slot_out;
      logic custom_logic_out_a;
      logic custom_logic_out_b;
      logic conversion_done_flag;
      logic ready;
      logic relay;
      logic grp_tgl;
      logic batch_tgl;
   } word_t;

   typedef struct packed {
      state_t st;
      mode_t mode;
      logic ext_trig;
      logic relay_en;
      logic [4:0] cfg_a;
      logic [4:0] cfg_b;
      logic [6:0] scan_len;
      logic [6:0] count;
      logic trg_s1;
      logic trg_s2;
      logic trg_l;
      logic ack_s1;
      logic ack_s2;
      logic req;
      word_t sent;
      word_t cur;
      logic meas_start;
      logic [31:0] rdata;
   } core_t;

   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic trg_s1;
      logic trg_s2;
      logic trg_l;
      logic trg_tgl;
      logic req_s1;
      logic req_s2;
      logic req_l;
      logic ack;
      logic stage;
      logic [`PULSE_W-1:0] gcnt;
      logic [`PULSE_W-1:0] bcnt;
      word_t word;
      logic [`NUM_PINS:1] pins;
   } link_t;

endpackage

`default_nettype wire

// File: hw/handler_scan_result_io.sv
// Purpose: Result signalling for a handler/scan connector of a resistance meter.
// Assumes: Grading inputs come from logic on clk; the connector side runs on link_clk.
// Notes: Results cross to link_clk by a toggle handshake with held data.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`include "handler_io_params.svh"
`default_nettype none

module handler_scan_result_io #(
   parameter int MAX_GROUPS = `SCAN_MAX,
   parameter int PULSE_CYC = `PULSE_CYC
) (
   // System clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rd_data,
   // Measurement engine
   output logic meas_start,
   input wire logic adc_done,
   input wire logic meas_done,
   input wire logic res_above,
   input wire logic res_below,
   input wire logic [7:0] res_slot_hit,
   // Connector
   input wire logic link_clk,
   input wire logic trigger_pin,
   output logic [`NUM_PINS:1] pin_out
);
   import handler_io_pkg::*;

   if (MAX_GROUPS < 1 || MAX_GROUPS > 127) begin : g_bad_groups
      $error("MAX_GROUPS must lie in 1..127");
   end
   if (PULSE_CYC < 1 || PULSE_CYC > 15) begin : g_bad_pulse
      $error("PULSE_CYC must lie in 1..15");
   end

   localparam logic [6:0] MAX_LEN = 7'(MAX_GROUPS);
   localparam logic [`PULSE_W-1:0] PULSE = `PULSE_W'(PULSE_CYC);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Lowest matching range wins, so at most one slot is driven
   function automatic logic [7:0] first_slot(input logic [7:0] hit);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         if (hit[i]) begin
            r = 8'h00;
            r[i] = 1'b1;
         end
      end
      return r;
   endfunction

   // cfg[3:0] selects {slot_out, low, high, pass}, cfg[4] is the level when met
   function automatic logic user_eval(input logic [4:0] cfg, input logic pass,
                                      input logic high, input logic low,
                                      input logic slot_out);
      logic met;
      met = |(cfg[3:0] & {slot_out, low, high, pass});
      return met ? cfg[4] : ~cfg[4];
   endfunction

   core_t cq;
   core_t cd;
   link_t lq;
   link_t ld;
   logic trig_ev;
   logic busy;

   assign trig_ev = cq.trg_s2 != cq.trg_l;
   assign busy = cq.req != cq.ack_s2;
   assign rd_data = cq.rdata;
   assign meas_start = cq.meas_start;
   assign pin_out = lq.pins;

   // ----------------------------------------
   // System clock domain
   // ----------------------------------------
   always_comb begin
      logic hi;
      logic lo;
      logic ok;
      logic [7:0] slots;
      logic none;
      hi = res_above;
      lo = res_below & ~res_above;
      ok = ~(hi | lo);
      slots = first_slot(res_slot_hit);
      none = ~|res_slot_hit;
      cd = cq;
      cd.meas_start = 1'b0;
      cd.rdata = 32'h0000_0000;
      cd.trg_s1 = lq.trg_tgl;
      cd.trg_s2 = cq.trg_s1;
      cd.trg_l = cq.trg_s2;
      cd.ack_s1 = lq.ack;
      cd.ack_s2 = cq.ack_s1;

      if (wr_en) begin
         case (addr)
            `REG_CTRL: begin
               cd.mode = mode_t'(wr_data[1:0]);
               cd.ext_trig = wr_data[`CTRL_EXT_BIT];
               cd.relay_en = wr_data[`CTRL_RELAY_BIT];
            end
            `REG_USER: begin
               cd.cfg_a = wr_data[4:0];
               cd.cfg_b = wr_data[`USER_B_LSB +: 5];
            end
            `REG_SCAN: begin
               // Out-of-range lengths fall back to the full batch
               if (wr_data[6:0] == 7'h00 || wr_data[6:0] > MAX_LEN || |wr_data[31:7]) begin
                  cd.scan_len = MAX_LEN;
               end else begin
                  cd.scan_len = wr_data[6:0];
               end
            end
            default: ;
         endcase
      end

      if (rd_en) begin
         case (addr)
            `REG_CTRL: cd.rdata = {28'h000_0000, cq.relay_en, cq.ext_trig, cq.mode};
            `REG_USER: cd.rdata = {19'h0_0000, cq.cfg_b, 3'h0, cq.cfg_a};
            `REG_SCAN: cd.rdata = {25'h000_0000, cq.scan_len};
            `REG_STAT: cd.rdata = {cq.cur.grade_slots, 4'h0, cq.cur.slot_out, cq.cur.low,
                                   cq.cur.high, cq.cur.pass, 1'b0, cq.count, 3'h0,
                                   cq.cur.ready, cq.cur.conversion_done_flag, busy, cq.st};
            default: cd.rdata = 32'h0000_0000;
         endcase
      end

      case (cq.st)
         ST_IDLE: begin
            cd.cur.ready = cq.ext_trig && (cq.mode == MODE_CMP || cq.mode == MODE_BIN);
            if (trig_ev && cq.mode != MODE_OFF) begin
               cd.meas_start = 1'b1;
               cd.cur.ready = 1'b0;
               cd.cur.conversion_done_flag = 1'b0;
               cd.count = 7'h00;
               cd.cur.relay = cq.mode == MODE_SCAN && cq.relay_en;
               cd.st = ST_MEAS;
            end
         end
         ST_MEAS: begin
            if (adc_done || meas_done) begin
               cd.cur.conversion_done_flag = cq.ext_trig && cq.mode != MODE_SCAN;
            end
            if (meas_done) begin
               cd.cur.high = hi;
               cd.cur.low = lo;
               cd.cur.pass = ok;
               cd.cur.fail = hi | lo;
               cd.cur.grade_slots = slots;
               cd.cur.slot_out = none;
               cd.cur.custom_logic_out_a = user_eval(cq.cfg_a, ok, hi, lo, none);
               cd.cur.custom_logic_out_b = user_eval(cq.cfg_b, ok, hi, lo, none);
               if (cq.mode == MODE_SCAN) begin
                  cd.cur.grp_tgl = ~cq.cur.grp_tgl;
                  cd.count = cq.count + 7'h01;
                  cd.st = ST_SEND;
               end else begin
                  cd.cur.ready = cq.ext_trig && cq.mode != MODE_OFF;
                  cd.st = ST_IDLE;
               end
            end
         end
         ST_SEND: begin
            // Next part only once the group has reached the connector
            if (!busy && cq.sent == cq.cur) begin
               if (cq.count >= cq.scan_len) begin
                  cd.cur.batch_tgl = ~cq.cur.batch_tgl;
                  cd.cur.relay = 1'b0;
                  cd.st = ST_LAST;
               end else begin
                  cd.meas_start = 1'b1;
                  cd.st = ST_MEAS;
               end
            end
         end
         ST_LAST: begin
            if (!busy && cq.sent == cq.cur) begin
               cd.st = ST_IDLE;
            end
         end
         default: cd.st = ST_IDLE;
      endcase

      cd.cur.mode = cd.mode;
      // Latest state is sent; data held until the link acknowledges
      if (!busy && cq.sent != cq.cur) begin
         cd.sent = cq.cur;
         cd.req = ~cq.req;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cq <= '0;
         cq.scan_len <= MAX_LEN;
      end else begin
         cq <= cd;
      end
   end

   // ----------------------------------------
   // Link clock domain
   // ----------------------------------------
   always_comb begin
      logic r1;
      logic r2;
      word_t w;
      r1 = rst;
      r2 = lq.rst_s1;
      w = lq.word;
      ld = lq;
      ld.rst_s1 = r1;
      ld.rst_s2 = r2;
      ld.trg_s1 = trigger_pin;
      ld.trg_s2 = lq.trg_s1;
      ld.trg_l = lq.trg_s2;
      if (lq.trg_s2 && !lq.trg_l) begin
         ld.trg_tgl = ~lq.trg_tgl;
      end
      ld.req_s1 = cq.req;
      ld.req_s2 = lq.req_s1;
      ld.req_l = lq.req_s2;
      ld.stage = 1'b0;
      if (!lq.stage && lq.gcnt != '0) begin
         ld.gcnt = lq.gcnt - `PULSE_W'(1);
      end
      if (!lq.stage && lq.gcnt == '0 && lq.bcnt != '0) begin
         ld.bcnt = lq.bcnt - `PULSE_W'(1);
      end
      if (lq.req_s2 != lq.req_l) begin
         // Stage holds ready and clock back one cycle behind the grades
         ld.word = cq.sent;
         ld.ack = lq.req_s2;
         ld.stage = 1'b1;
         if (cq.sent.grp_tgl != lq.word.grp_tgl) begin
            ld.gcnt = PULSE;
         end
         if (cq.sent.batch_tgl != lq.word.batch_tgl) begin
            ld.bcnt = PULSE;
         end
      end

      ld.pins = '0;
      case (w.mode)
         MODE_CMP, MODE_BIN: begin
            if (w.mode == MODE_CMP) begin
               ld.pins[`PIN_FAIL] = w.fail;
               ld.pins[`PIN_HIGH] = w.high;
               ld.pins[`PIN_PASS] = w.pass;
               ld.pins[`PIN_LOW] = w.low;
            end else begin
               ld.pins[`PIN_SLOT1] = w.grade_slots[0];
               ld.pins[`PIN_SLOT2] = w.grade_slots[1];
               ld.pins[`PIN_SLOT3] = w.grade_slots[2];
               ld.pins[`PIN_SLOT4] = w.grade_slots[3];
               ld.pins[`PIN_SLOT5] = w.grade_slots[4];
               ld.pins[`PIN_SLOT6] = w.grade_slots[5];
               ld.pins[`PIN_SLOT7] = w.grade_slots[6];
               ld.pins[`PIN_SLOT8] = w.grade_slots[7];
               ld.pins[`PIN_SLOT_OUT] = w.slot_out;
            end
            ld.pins[`PIN_USER_A] = w.custom_logic_out_a;
            ld.pins[`PIN_USER_B] = w.custom_logic_out_b;
            ld.pins[`PIN_CONV_DONE] = w.conversion_done_flag;
            ld.pins[`PIN_READY] = w.ready && !lq.stage;
         end
         MODE_SCAN: begin
            ld.pins[`PIN_S_HIGH] = w.high;
            ld.pins[`PIN_S_LOW] = w.low;
            ld.pins[`PIN_S_PASS] = w.pass;
            ld.pins[`PIN_S_RELAY] = w.relay;
            ld.pins[`PIN_S_CLOCK] = lq.gcnt != '0 && !lq.stage;
            ld.pins[`PIN_S_BATCH] = lq.bcnt != '0 && lq.gcnt == '0 && !lq.stage;
         end
         default: ;
      endcase

      // Reset released through a two-stage synchroniser
      if (lq.rst_s2) begin
         ld = '0;
         ld.rst_s1 = r1;
         ld.rst_s2 = r2;
      end
   end

   always_ff @(posedge link_clk) begin
      lq <= ld;
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   trig_starts_a: assert property (
      @(posedge clk) disable iff (rst)
      trig_ev && cq.st == ST_IDLE && cq.mode != MODE_OFF |=> meas_start && cq.st == ST_MEAS)
      else $error("trigger did not start one measurement");

   one_start_a: assert property (
      @(posedge clk) disable iff (rst)
      meas_start && cq.mode != MODE_SCAN |=> !meas_start [*2])
      else $error("second start without trigger");

   fail_grade_a: assert property (
      @(posedge clk) disable iff (rst)
      cq.st == ST_MEAS && meas_done |=> cq.cur.fail == (cq.cur.high || cq.cur.low))
      else $error("fail does not match high or low");

   high_grade_a: assert property (
      @(posedge clk) disable iff (rst)
      cq.st == ST_MEAS && meas_done && res_above |=> cq.cur.high && !cq.cur.pass)
      else $error("above limit not graded high");

   low_grade_a: assert property (
      @(posedge clk) disable iff (rst)
      cq.st == ST_MEAS && meas_done && res_below && !res_above |=> cq.cur.low && !cq.cur.high)
      else $error("below limit not graded low");

   pass_grade_a: assert property (
      @(posedge clk) disable iff (rst)
      cq.st == ST_MEAS && meas_done && !res_above && !res_below |=> cq.cur.pass && !cq.cur.fail)
      else $error("in-limit result not graded pass");

   slot_choice_a: assert property (
      @(posedge clk) disable iff (rst)
      cq.st == ST_MEAS && meas_done |=> $onehot(cq.cur.grade_slots) != cq.cur.slot_out)
      else $error("slot outputs not one-hot or out flag wrong");

   ready_done_a: assert property (
      @(posedge clk) disable iff (rst)
      cq.st == ST_MEAS && meas_done && cq.ext_trig && cq.mode == MODE_CMP
      |=> cq.cur.ready && cq.cur.conversion_done_flag && cq.st == ST_IDLE)
      else $error("ready or conversion flag missing after measurement");

   scan_bound_a: assert property (
      @(posedge clk) disable iff (rst)
      cq.count <= MAX_LEN)
      else $error("scan group count exceeds batch limit");

   ready_after_a: assert property (
      @(posedge link_clk) disable iff (lq.rst_s2)
      $rose(pin_out[`PIN_READY]) && lq.word.mode == MODE_CMP
      |-> $stable(pin_out[`PIN_PASS]) && $stable(pin_out[`PIN_FAIL]))
      else $error("grade changed together with ready");

   group_clock_a: assert property (
      @(posedge link_clk) disable iff (lq.rst_s2)
      $rose(pin_out[`PIN_S_CLOCK]) && lq.word.mode == MODE_SCAN
      |-> $stable(pin_out[`PIN_S_PASS]) ##1 pin_out[`PIN_S_CLOCK] == (PULSE_CYC > 1))
      else $error("group clock unstable grade or short pulse");

   map_idle_a: assert property (
      @(posedge link_clk) disable iff (lq.rst_s2)
      lq.word.mode == MODE_OFF |=> pin_out == '0)
      else $error("pins driven with no active mode");

endmodule

`default_nettype wire

// File: dv/handler_model.sv
// Purpose: Handler model on the connector side of the result block.
// Assumes: pin_out is indexed by pin number; link_clk runs free.
// Notes: Counts group clock and batch pulses only while scan is selected.
`include "handler_io_params.svh"
`default_nettype none

module handler_model (
   // Connector
   input wire logic link_clk,
   input wire logic [`NUM_PINS:1] pin_out,
   output logic trigger_pin,
   // Bench view
   input wire logic scan_sel
);
   timeunit 1ns;
   timeprecision 1ps;

   int n_groups = 0;
   int n_batch = 0;
   int gw = 0;
   int bw = 0;
   int hc = 0;
   int hb = 0;
   logic [3:0] cap [0:3];

   initial trigger_pin = 1'b0;

   // Held four link cycles so that the edge is never missed
   task automatic pulse_trigger();
      @(posedge link_clk);
      trigger_pin <= 1'b1;
      repeat (4) @(posedge link_clk);
      trigger_pin <= 1'b0;
   endtask

   // ----------
   // Scan group capture
   // ----------
   always @(posedge link_clk) begin
      if (scan_sel) begin
         if (pin_out[`PIN_S_CLOCK]) begin
            if (hc == 0 && n_groups < 4) begin
               cap[n_groups] <= {pin_out[`PIN_S_RELAY], pin_out[`PIN_S_PASS],
                                 pin_out[`PIN_S_LOW], pin_out[`PIN_S_HIGH]};
            end
            if (hc == 0) begin
               n_groups <= n_groups + 1;
            end
            hc <= hc + 1;
         end else if (hc != 0) begin
            gw <= hc;
            hc <= 0;
         end
         if (pin_out[`PIN_S_BATCH]) begin
            hb <= hb + 1;
         end else if (hb != 0) begin
            bw <= hb;
            hb <= 0;
            n_batch <= n_batch + 1;
         end
      end
   end
endmodule

`default_nettype wire

// File: dv/handler_scan_result_io_tb_top.sv
// Purpose: Self-checking bench for the handler/scan result block.
// Assumes: Measurement engine is modelled here on clk.
// Notes: PULSE_CYC set to 3 so pulse widths differ from the default.
`include "handler_io_params.svh"
`default_nettype none

module handler_scan_result_io_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int PCYC = 3;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wr_data = 32'h0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [31:0] rd_data;
   logic meas_start;
   logic adc_done = 1'b0;
   logic meas_done = 1'b0;
   logic res_above = 1'b0;
   logic res_below = 1'b0;
   logic [7:0] res_slot_hit = 8'h00;
   logic trigger_pin;
   logic [`NUM_PINS:1] pin_out;
   logic [`NUM_PINS:1] e;
   logic scan_sel = 1'b0;
   logic [31:0] d;
   int n_errors = 0;
   int total_checks = 0;
   int n_starts = 0;
   int cyc = 0;
   int eng = 0;
   int idx = 0;
   int cur_g = 0;
   int cur_s = 8;
   int gq;
   int slot_pin [8] = '{`PIN_SLOT1, `PIN_SLOT2, `PIN_SLOT3, `PIN_SLOT4,
                        `PIN_SLOT5, `PIN_SLOT6, `PIN_SLOT7, `PIN_SLOT8};

   initial forever #20 clk = ~clk;
   initial begin
      #7;
      forever #15 link_clk = ~link_clk;
   end

   handler_scan_result_io #(.PULSE_CYC(PCYC)) i_dut (.clk(clk), .rst(rst), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .meas_start(meas_start), .adc_done(adc_done), .meas_done(meas_done),
      .res_above(res_above), .res_below(res_below), .res_slot_hit(res_slot_hit),
      .link_clk(link_clk), .trigger_pin(trigger_pin), .pin_out(pin_out));

   handler_model i_handler (.link_clk(link_clk), .pin_out(pin_out),
      .trigger_pin(trigger_pin), .scan_sel(scan_sel));

   // ----------
   // Measurement engine, slow so that ready is seen low
   // ----------
   always @(posedge clk) begin
      gq = (cur_g == 3) ? idx % 3 : cur_g;
      if (meas_start === 1'b1) begin
         n_starts <= n_starts + 1;
         eng <= 20;
      end else if (eng > 0) begin
         eng <= eng - 1;
      end
      adc_done <= (eng == 11);
      meas_done <= (eng == 2);
      if (meas_done) idx <= idx + 1;
      if (eng == 3) begin
         res_above <= (gq == 1);
         res_below <= (gq == 2);
         res_slot_hit <= (cur_s < 8) ? (8'h01 << cur_s) : 8'h00;
      end
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_errors++;
         end_sim();
      end
   end

   task automatic end_sim();
      if (n_errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk_word(input string nm, input logic [31:0] x, input logic [31:0] g);
      total_checks++;
      if (g !== x) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, x, g);
      end
   endtask

   task automatic chk_pins(input string nm, input logic [`NUM_PINS:1] x,
                           input logic [`NUM_PINS:1] g);
      total_checks++;
      if (g !== x) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, x, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 v = rd_data;
   endtask

   task automatic wait_pin(input int p, input logic v);
      for (int n = 0; n < 500 && pin_out[p] !== v; n++) @(posedge clk);
      chk_word("ready pin", {31'h0, v}, {31'h0, pin_out[p]});
   endtask

   function automatic logic cust(input logic [4:0] c, input logic [3:0] cond);
      return (|(c[3:0] & cond)) ? c[4] : ~c[4];
   endfunction

   task automatic measure(input int g, input int s);
      int s0;
      s0 = n_starts;
      cur_g = g;
      cur_s = s;
      i_handler.pulse_trigger();
      for (int n = 0; n < 200 && n_starts == s0; n++) @(posedge clk);
      wait_pin(`PIN_READY, 1'b0);
      wait_pin(`PIN_READY, 1'b1);
      chk_word("starts", 32'(s0 + 1), 32'(n_starts));
      e = '0;
      e[`PIN_CONV_DONE] = 1'b1;
      e[`PIN_READY] = 1'b1;
   endtask

   task automatic run_scan(input int ng);
      int s0;
      int g0;
      int b0;
      s0 = n_starts;
      g0 = i_handler.n_groups;
      b0 = i_handler.n_batch;
      i_handler.pulse_trigger();
      for (int n = 0; n < 20000 && i_handler.n_batch == b0; n++) @(posedge clk);
      chk_word("batches", 32'(b0 + 1), 32'(i_handler.n_batch));
      chk_word("groups", 32'(g0 + ng), 32'(i_handler.n_groups));
      chk_word("scan starts", 32'(s0 + ng), 32'(n_starts));
   endtask

   // ----------
   // Main sequence
   // ----------
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      chk_pins("reset pins", '0, pin_out);
      rd(`REG_CTRL, d);
      chk_word("ctrl reset", 32'h0, d);
      wr(8'h10, 32'hFFFFFFFF);
      rd(8'h10, d);
      chk_word("unmapped read", 32'h0, d);
      @(posedge clk);
      #1 chk_word("rd after", 32'h0, rd_data);
      wr(`REG_USER, 32'h00000211);
      wr(`REG_CTRL, 32'h4);
      rd(`REG_CTRL, d);
      chk_word("ctrl", 32'h4, d);
      rd(`REG_USER, d);
      chk_word("user cfg", 32'h0000_0211, d);
      for (int g = 0; g < 3; g++) begin
         measure(g, 8);
         e[`PIN_FAIL] = (g != 0);
         e[`PIN_HIGH] = (g == 1);
         e[`PIN_LOW] = (g == 2);
         e[`PIN_PASS] = (g == 0);
         e[`PIN_USER_A] = cust(5'h11, {1'b0, g == 2, g == 1, g == 0});
         e[`PIN_USER_B] = cust(5'h02, {1'b0, g == 2, g == 1, g == 0});
         chk_pins("compare pins", e, pin_out);
      end
      wr(`REG_USER, 32'h00000818);
      wr(`REG_CTRL, 32'h5);
      for (int s = 0; s < 9; s++) begin
         measure(0, s);
         if (s < 8) e[slot_pin[s]] = 1'b1;
         e[`PIN_SLOT_OUT] = (s == 8);
         e[`PIN_USER_A] = cust(5'h18, {s == 8, 3'b000});
         e[`PIN_USER_B] = cust(5'h08, {s == 8, 3'b000});
         chk_pins("bin pins", e, pin_out);
      end
      scan_sel = 1'b1;
      idx = 0;
      cur_g = 3;
      cur_s = 8;
      wr(`REG_SCAN, 32'h3);
      rd(`REG_SCAN, d);
      chk_word("scan len", 32'h0000_0003, d);
      wr(`REG_CTRL, 32'hA);
      run_scan(3);
      for (int i = 0; i < 3; i++) begin
         chk_word("group", {28'h0, 1'b1, i == 0, i == 2, i == 1},
                  {28'h0, i_handler.cap[i]});
      end
      chk_word("group clock width", 32'(PCYC), 32'(i_handler.gw));
      chk_word("batch width", 32'(PCYC), 32'(i_handler.bw));
      e = '1;
      e[`PIN_S_HIGH] = 1'b0;
      e[`PIN_S_CLOCK] = 1'b0;
      e[`PIN_S_LOW] = 1'b0;
      e[`PIN_S_PASS] = 1'b0;
      chk_pins("scan spare pins", '0, pin_out & e);
      chk_word("relay after", 32'h0, {31'h0, pin_out[`PIN_S_RELAY]});
      // Idle, three groups done, last group low, no slot hit
      rd(`REG_STAT, d);
      chk_word("status after scan", 32'h000C_0300, d);
      wr(`REG_SCAN, 32'h0);
      rd(`REG_SCAN, d);
      chk_word("scan len full", 32'h0000_0064, d);
      run_scan(100);
      scan_sel = 1'b0;
      wr(`REG_CTRL, 32'h3);
      repeat (30) @(posedge clk);
      chk_pins("off pins", '0, pin_out);
      d = 32'(n_starts);
      i_handler.pulse_trigger();
      repeat (60) @(posedge clk);
      chk_word("off starts", d, 32'(n_starts));
      end_sim();
   end
endmodule

`default_nettype wire
